// file: rtl/pdst_selftest_ctrl.sv
// Self-test control, PRBS checker and carrier pattern transmitter
`timescale 1ns/10ps
`default_nettype none
`include "pdst_defines.svh"

module pdst_selftest_ctrl
	import pdst_pkg::*;
#(
	parameter int BIT_CYC = (`PDST_BIT_NS * `PDST_CLK_MHZ) / 1000
)
(
	input  wire logic          clk,
	input  wire logic          srst,
	input  wire pdst_bus_req_t bus_req,
	output logic [7:0]         rd_data,
	input  wire logic          rx_bit_valid,
	input  wire logic          rx_bit,
	input  wire logic          hard_reset_in,
	output logic               func_rx_valid,
	output logic               func_rx_bit,
	output logic               hard_reset_det,
	output logic               bmc_tx_power,
	output logic               tx_busy,
	output logic               tx_bit
);
	localparam int CW = (BIT_CYC > 1) ? $clog2(BIT_CYC) : 1;
	localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYC - 1);

	logic           rx_en_q;
	logic           en_q;
	logic [2:0]     mode_q;
	logic           loop_q;
	logic [8:0]     lfsr_q;
	logic [15:0]    cnt_q;
	logic [7:0]     rd_data_q;
	logic           func_valid_q;
	logic           func_bit_q;
	logic           hr_det_q;
	pdst_tx_state_t state_q;
	logic [CW-1:0]  bit_cnt_q;
	logic           tx_bit_q;

	logic wr_a;
	logic wr_b;
	logic wr_l;
	logic rx_arm;
	logic clr_cnt;
	logic exp_bit;
	logic mismatch;
	logic trig;
	logic txrst;
	logic bit_wrap;
	logic block;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	assign wr_a = bus_req.wr && bus_req.addr == `PDST_OFS_CTRL_A;
	assign wr_b = bus_req.wr && bus_req.addr == `PDST_OFS_CTRL_B;
	assign wr_l = bus_req.wr && bus_req.addr == `PDST_OFS_LOOP;

	// Only a 0 to 1 step rearms; rewriting a set bit leaves the test running
	assign rx_arm = wr_a && bus_req.wdata[`PDST_A_RX_EN] && !rx_en_q; // R2
	assign clr_cnt = rx_arm || (wr_b && bus_req.wdata[`PDST_B_CLRERR]); // R3

	// Bit at the top of the checker is the next expected PRBS9 bit
	assign exp_bit = lfsr_q[8];
	assign mismatch = rx_en_q && rx_bit_valid && (rx_bit != exp_bit); // R16

	// Reset wins over start when both are written together
	assign txrst = wr_b && bus_req.wdata[`PDST_B_TXRST];
	assign trig = wr_b && bus_req.wdata[`PDST_B_TRIG] && !txrst; // R14
	assign bit_wrap = bit_cnt_q == BIT_LAST;

	assign block = en_q && loop_q; // R7

	// Control register A
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rx_en_q <= 1'b0;
			en_q <= 1'b0;
			mode_q <= `PDST_MODE_RST; // R13
		end
		else if (wr_a)
		begin
			rx_en_q <= bus_req.wdata[`PDST_A_RX_EN]; // R1
			en_q <= bus_req.wdata[`PDST_A_EN];
			mode_q <= bus_req.wdata[`PDST_A_MODE_HI:`PDST_A_MODE_LO]; // R13
		end
	end

	// Loopback control
	always_ff @(posedge clk)
	begin
		if (srst)
			loop_q <= 1'b0;
		else if (wr_l)
			loop_q <= bus_req.wdata[`PDST_L_LOOP];
	end

	// Receive PRBS checker, free of the functional path so loopback still checks
	always_ff @(posedge clk)
	begin
		if (srst)
			lfsr_q <= `PDST_PRBS_SEED;
		else if (rx_arm)
			lfsr_q <= `PDST_PRBS_SEED; // R2
		else if (rx_en_q && rx_bit_valid)
			lfsr_q <= {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};
	end

	// Error counter saturates; a mismatch in the clearing cycle still counts
	always_ff @(posedge clk)
	begin
		if (srst)
			cnt_q <= 16'h0000;
		else if (clr_cnt)
			cnt_q <= mismatch ? 16'h0001 : 16'h0000; // R3
		else if (mismatch && cnt_q != `PDST_CNT_MAX)
			cnt_q <= cnt_q + 16'h0001; // R16
	end

	// Functional receive path gate
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			func_valid_q <= 1'b0;
			func_bit_q <= 1'b0;
			hr_det_q <= 1'b0;
		end
		else
		begin
			func_valid_q <= rx_bit_valid && !block; // R7
			func_bit_q <= rx_bit && !block;
			hr_det_q <= hard_reset_in && !block; // R8
		end
	end

	// Carrier transmitter; unsupported pattern codes never start it
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_q <= PDST_IDLE;
			bit_cnt_q <= '0;
			tx_bit_q <= 1'b0;
		end
		else if (!en_q)
		begin
			state_q <= PDST_IDLE; // R9
			bit_cnt_q <= '0;
			tx_bit_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				PDST_IDLE:
				begin
					bit_cnt_q <= '0;
					tx_bit_q <= 1'b0;
					if (trig && mode_q == `PDST_MODE_CARR2) // R11
						state_q <= PDST_RUN; // R14
				end
				PDST_RUN:
				begin
					bit_cnt_q <= bit_wrap ? '0 : bit_cnt_q + 1'b1;
					if (bit_wrap)
						tx_bit_q <= !tx_bit_q; // R11
					if (txrst)
						state_q <= PDST_DRAIN;
				end
				PDST_DRAIN:
				begin
					// Let the bit in flight finish rather than chop the line
					bit_cnt_q <= bit_wrap ? '0 : bit_cnt_q + 1'b1;
					if (bit_wrap)
						state_q <= PDST_IDLE;
				end
				default:
					state_q <= PDST_IDLE;
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (srst)
			rd_data_q <= 8'h00;
		else if (!bus_req.rd)
			rd_data_q <= 8'h00;
		else
		begin
			case (bus_req.addr)
				`PDST_OFS_CTRL_A:
					rd_data_q <= {3'h0, rx_en_q, en_q, mode_q}; // R13
				`PDST_OFS_CTRL_B:
					rd_data_q <= {7'h00, tx_busy}; // R14
				`PDST_OFS_ERR_HI:
					rd_data_q <= cnt_q[15:8]; // R15
				`PDST_OFS_ERR_LO:
					rd_data_q <= cnt_q[7:0]; // R15
				`PDST_OFS_LOOP:
					rd_data_q <= {7'h00, loop_q};
				default:
					rd_data_q <= 8'h00;
			endcase
		end
	end

	assign rd_data = rd_data_q;
	assign func_rx_valid = func_valid_q;
	assign func_rx_bit = func_bit_q;
	assign hard_reset_det = hr_det_q;
	assign bmc_tx_power = en_q; // R9
	assign tx_busy = state_q != PDST_IDLE;
	assign tx_bit = tx_bit_q;

	property p_rx_enable;
		wr_a && bus_req.wdata[`PDST_A_RX_EN] |=> rx_en_q;
	endproperty
	a_rx_enable: assert property (p_rx_enable) // R1
		else $error("receiver not enabled after write");

	property p_reseed;
		rx_arm |=> lfsr_q == `PDST_PRBS_SEED;
	endproperty
	a_reseed: assert property (p_reseed) // R2
		else $error("checker not reseeded on receive enable");

	property p_arm_clear;
		rx_arm && !mismatch |=> cnt_q == 16'h0000;
	endproperty
	a_arm_clear: assert property (p_arm_clear) // R3
		else $error("error counter not cleared on receive enable");

	property p_block;
		block |=> !func_rx_valid && !func_rx_bit;
	endproperty
	a_block: assert property (p_block) // R7
		else $error("received data leaked in loopback");

	property p_no_hard_reset;
		block |=> !hard_reset_det;
	endproperty
	a_no_hard_reset: assert property (p_no_hard_reset) // R8
		else $error("hard reset seen in loopback");

	// The carrier may run one cycle past the enable; it must be quiet after
	property p_power;
		!bmc_tx_power |=> !tx_busy && !tx_bit;
	endproperty
	a_power: assert property (p_power) // R9
		else $error("transmitting while unpowered");

	property p_mode;
		$rose(tx_busy) |-> $past(mode_q) == `PDST_MODE_CARR2;
	endproperty
	a_mode: assert property (p_mode) // R11
		else $error("transmit started with reserved pattern");

	property p_toggle;
		state_q == PDST_RUN && en_q && bit_wrap |=> tx_bit != $past(tx_bit);
	endproperty
	a_toggle: assert property (p_toggle) // R11
		else $error("carrier did not alternate");

	property p_reserved;
		bus_req.rd && bus_req.addr == `PDST_OFS_CTRL_A |=> rd_data[7:5] == 3'h0;
	endproperty
	a_reserved: assert property (p_reserved) // R13
		else $error("reserved bits read nonzero");

	property p_status;
		bus_req.rd && bus_req.addr == `PDST_OFS_CTRL_B
			|=> rd_data[0] == $past(tx_busy);
	endproperty
	a_status: assert property (p_status) // R14
		else $error("trigger status wrong");

	property p_count;
		mismatch && !clr_cnt && cnt_q != `PDST_CNT_MAX
			|=> cnt_q == $past(cnt_q) + 16'h0001;
	endproperty
	a_count: assert property (p_count) // R16
		else $error("mismatch not counted");

	property p_cov_tx;
		trig && state_q == PDST_IDLE ##1 tx_busy ##[1:200] !tx_busy;
	endproperty
	c_cov_tx: cover property (p_cov_tx);

	property p_cov_err;
		rx_arm ##[1:50] mismatch;
	endproperty
	c_cov_err: cover property (p_cov_err);

	property p_cov_loop;
		block && rx_en_q && rx_bit_valid;
	endproperty
	c_cov_loop: cover property (p_cov_loop);
endmodule

`default_nettype wire

// file: rtl/pdst_defines.svh
// Constants of the PD MAC self-test control block
//
// Operation
// (R1) Setting receive-enable bit 4 turns the self-test receiver on.
// (R2) Setting receive-enable reseeds the receive PRBS checker to its first bit.
// (R3) Setting receive-enable clears both bytes of the error counter.
// (R4) Software clears then sets receive-enable for every new receive request.
// (R5) Loopback test: set receive-enable, auto response off, loopback on.
// (R6) In loopback, software triggers every transmitted self-test packet itself.
// (R7) Self-test enable plus loopback blocks received data from the functional path.
// (R8) In that loopback state hard reset signalling is not detected.
// (R9) Self-test enable bit 3 powers up the BMC transmitter.
// (R10) Software holds self-test enable at least 5us before triggering.
// (R11) Pattern field 2:0 supports only 010b, alternating ones and zeros.
// (R12) Software writes no pattern code other than the supported one.
// (R13) Pattern field is read-write, resets to 000b; bits 7:5 read zero.
// (R14) Writing trigger starts a self-test frame; reading it gives status.
// (R15) Error counter is 16 bits, read as upper and lower bytes.
// (R16) Each received bit mismatching the local PRBS increments the counter.
`ifndef PDST_DEFINES_SVH
`define PDST_DEFINES_SVH

`define PDST_OFS_CTRL_A   16'h1ac0
`define PDST_OFS_CTRL_B   16'h1ac1
`define PDST_OFS_ERR_HI   16'h1ac2
`define PDST_OFS_ERR_LO   16'h1ac3
`define PDST_OFS_LOOP     16'h1ac8

`define PDST_A_RX_EN      4
`define PDST_A_EN         3
`define PDST_A_MODE_HI    2
`define PDST_A_MODE_LO    0
`define PDST_B_TRIG       0
`define PDST_B_TXRST      1
`define PDST_B_CLRERR     2
`define PDST_L_LOOP       0

`define PDST_MODE_RST     3'h0
`define PDST_MODE_CARR2   3'h2
`define PDST_PRBS_SEED    9'h1ff
`define PDST_CNT_MAX      16'hffff

`define PDST_CLK_MHZ      10
`define PDST_BIT_NS       3333

`endif

// file: rtl/pdst_pkg.sv
// Types of the PD MAC self-test control block
package pdst_pkg;
	typedef struct packed
	{
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} pdst_bus_req_t;

	typedef enum logic [1:0]
	{
		PDST_IDLE  = 2'b00,
		PDST_RUN   = 2'b01,
		PDST_DRAIN = 2'b11
	} pdst_tx_state_t;
endpackage

// file: tb/pdst_partner_model.sv
// Port partner on the CC wire: sends a PRBS9 self-test bit stream
`timescale 1ns/10ps
`default_nettype none

module pdst_partner_model
(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       start,
	input  wire logic [7:0] n_bits,
	input  wire logic [7:0] err_idx,
	output logic            rx_bit_valid,
	output logic            rx_bit,
	output logic            busy
);
	logic [8:0] lfsr_q;
	logic [7:0] sent_q;
	logic [1:0] gap_q;

	// Between bits the line is not held, so it toggles every cycle
	always_ff @(posedge clk)
	begin
		if (srst || start)
		begin
			lfsr_q       <= 9'h1ff;
			sent_q       <= 8'h00;
			gap_q        <= 2'h0;
			rx_bit       <= 1'b0;
			busy         <= start;
			rx_bit_valid <= 1'b0;
		end
		else if (busy && gap_q == 2'h3)
		begin
			rx_bit_valid <= 1'b1;
			rx_bit       <= lfsr_q[8] ^ (sent_q == err_idx);
			lfsr_q       <= {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};
			sent_q       <= sent_q + 8'h01;
			busy         <= (sent_q + 8'h01) < n_bits;
			gap_q        <= 2'h0;
		end
		else
		begin
			rx_bit_valid <= 1'b0;
			rx_bit       <= ~rx_bit;
			gap_q        <= gap_q + 2'h1;
		end
	end
endmodule
`default_nettype wire

// file: tb/pdst_selftest_ctrl_tb_top.sv
// Testbench of the PD MAC self-test control block
`timescale 1ns/10ps
`default_nettype none
`include "pdst_defines.svh"

module pdst_selftest_ctrl_tb_top
	import pdst_pkg::*;
;
	logic          clk;
	logic          srst;
	pdst_bus_req_t bus_req;
	logic [7:0]    rd_data;
	logic          rx_bit_valid;
	logic          rx_bit;
	logic          hard_reset_in;
	logic          func_rx_valid;
	logic          func_rx_bit;
	logic          hard_reset_det;
	logic          bmc_tx_power;
	logic          tx_busy;
	logic          tx_bit;
	logic          start;
	logic [7:0]    err_idx;
	logic          p_busy;
	logic          fv_seen = 1'b0;
	logic          fb_seen = 1'b0;
	int            mismatches;
	int            total_checks;

	pdst_selftest_ctrl #(.BIT_CYC(4)) i_pdst_selftest_ctrl
	(
		.clk(clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
		.rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
		.hard_reset_in(hard_reset_in), .func_rx_valid(func_rx_valid),
		.func_rx_bit(func_rx_bit), .hard_reset_det(hard_reset_det),
		.bmc_tx_power(bmc_tx_power), .tx_busy(tx_busy), .tx_bit(tx_bit)
	);

	pdst_partner_model i_pdst_partner_model
	(
		.clk(clk), .srst(srst), .start(start), .n_bits(8'h10),
		.err_idx(err_idx), .rx_bit_valid(rx_bit_valid),
		.rx_bit(rx_bit), .busy(p_busy)
	);

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (func_rx_valid === 1'b1)
			fv_seen <= 1'b1;
		if (func_rx_valid === 1'b1 && func_rx_bit === 1'b1)
			fb_seen <= 1'b1;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1;
		chk(rd_data, exp);
	endtask

	task automatic report_and_stop();
		if (mismatches == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Bounded waits; a hang counts as a mismatch and ends the run
	task automatic wait_low(ref logic s, input int lim);
		int n;
		n = 0;
		while (s !== 1'b0 && n < lim)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= lim)
		begin
			mismatches++;
			report_and_stop();
		end
	endtask

	task automatic send(input logic [7:0] e);
		@(posedge clk);
		err_idx <= e;
		start   <= 1'b1;
		@(posedge clk);
		start   <= 1'b0;
		repeat (2) @(posedge clk);
		wait_low(p_busy, 200);
		repeat (3) @(posedge clk);
	endtask

	initial
	begin
		srst          = 1'b1;
		bus_req       = '0;
		hard_reset_in = 1'b0;
		start         = 1'b0;
		err_idx       = 8'hff;
		mismatches    = 0;
		total_checks  = 0;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		rd(`PDST_OFS_CTRL_A, 8'h00);
		rd(`PDST_OFS_ERR_HI, 8'h00);
		wr(`PDST_OFS_CTRL_A, 8'hfa);
		rd(`PDST_OFS_CTRL_A, 8'h1a);
		wr(`PDST_OFS_LOOP, 8'h01);
		wr(`PDST_OFS_CTRL_A, 8'h0a);
		hard_reset_in <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk({7'h0, bmc_tx_power}, 8'h01);
		chk({7'h0, hard_reset_det}, 8'h00);
		// One bit error in sixteen gives a count of one
		wr(`PDST_OFS_CTRL_A, 8'h1a);
		send(8'h05);
		rd(`PDST_OFS_ERR_LO, 8'h01);
		rd(`PDST_OFS_ERR_HI, 8'h00);
		chk({7'h0, fv_seen}, 8'h00);
		chk({7'h0, fb_seen}, 8'h00);
		wr(`PDST_OFS_CTRL_A, 8'h0a);
		wr(`PDST_OFS_CTRL_A, 8'h1a);
		rd(`PDST_OFS_ERR_LO, 8'h00);
		send(8'hff);
		rd(`PDST_OFS_ERR_LO, 8'h00);
		wr(`PDST_OFS_LOOP, 8'h00);
		repeat (3) @(posedge clk);
		#1;
		chk({7'h0, hard_reset_det}, 8'h01);
		// With loopback off the bits must reach the functional path
		send(8'hff);
		chk({7'h0, fv_seen}, 8'h01);
		chk({7'h0, fb_seen}, 8'h01);
		// Self-test enable has been held far beyond 5us here
		wr(`PDST_OFS_CTRL_B, 8'h01);
		rd(`PDST_OFS_CTRL_B, 8'h01);
		repeat (2) @(posedge clk);
		#1;
		chk({7'h0, tx_bit}, 8'h01);
		repeat (4) @(posedge clk);
		#1;
		chk({7'h0, tx_bit}, 8'h00);
		wr(`PDST_OFS_CTRL_B, 8'h02);
		wait_low(tx_busy, 20);
		wr(`PDST_OFS_CTRL_B, 8'h03);
		rd(`PDST_OFS_CTRL_B, 8'h00);
		// A trigger with self-test disabled must not start the carrier
		wr(`PDST_OFS_CTRL_A, 8'h02);
		wr(`PDST_OFS_CTRL_B, 8'h01);
		rd(`PDST_OFS_CTRL_B, 8'h00);
		chk({7'h0, bmc_tx_power}, 8'h00);
		report_and_stop();
	end
endmodule
`default_nettype wire
